// [design/pscb_pkg.sv]
// package for the special control bits block: offsets, fields, resets, timing
// assumes a 32-bit axi4-lite slave and a 125 MHz management clock
package pscb_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0]  SPECIFIC_CONFIGURATION_OFS = 8'h10;
  localparam logic [7:0]  SM_RESET_LEN_OFS           = 8'h14;
  localparam logic [7:0]  STATUS_OFS                 = 8'h18;

  // field positions within specific_configuration
  localparam int          ARPD_BIT  = 4;
  localparam int          STATE_MACHINE_RESET_BIT = 3;
  localparam int          MPS_BIT   = 2;
  localparam int          SLEEP_BIT = 1;
  localparam int          RLO_BIT   = 0;

  // reset values
  localparam logic [15:0] CFG_RESET = 16'h0014;

  // state machine reset pulse: time in ns and derived cycles
  localparam int          CLK_PERIOD_NS     = 8;
  localparam int          SM_RESET_TIME_NS  = 80;
  localparam int          SM_RESET_CYCLES   =
    (SM_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // axi responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum {SM_IDLE, SM_RESET} pscb_sm_e;

endpackage

// [design/pscb_rst_timer.sv]
// down-counter that holds the internal state machine reset for a set length
// assumes start is a one-cycle pulse in the clk domain
`timescale 1ns/10ps
`default_nettype none
module pscb_rst_timer
  import pscb_pkg::*;
#(
  parameter int W = 8
)(
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         start,
  input  wire logic [W-1:0] len,
  output logic              busy,
  output logic              done
);

  typedef struct packed {
    pscb_sm_e     st;
    logic [W-1:0] cnt;
    logic         done;
  } pscb_tmr_s;

  pscb_tmr_s st_ff;
  pscb_tmr_s nxt_st;

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  // a restart while busy reloads the count, stretching the reset
  always_comb
  begin
    nxt_st      = st_ff;
    nxt_st.done = 1'b0;
    unique case (st_ff.st)
      SM_IDLE:
      begin
        if (start)
        begin
          nxt_st.st  = SM_RESET;
          nxt_st.cnt = (len == '0) ? W'(1) : len;
        end
      end
      SM_RESET:
      begin
        if (start)
          nxt_st.cnt = (len == '0) ? W'(1) : len;
        else if (st_ff.cnt == W'(1))
        begin
          nxt_st.st   = SM_IDLE;
          nxt_st.cnt  = '0;
          nxt_st.done = 1'b1;
        end
        else
          nxt_st.cnt = st_ff.cnt - W'(1);
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      st_ff <= '{st: SM_IDLE, cnt: '0, done: 1'b0};
    else
      st_ff <= nxt_st;
  end

  assign busy = (st_ff.st == SM_RESET);
  assign done = st_ff.done;

endmodule // pscb_rst_timer
`default_nettype wire

// [design/pscb_ctrl.sv]
// special control bits of the transceiver configuration register 0x10
// assumes an axi4-lite master on clk; outputs drive power, reset, datapath
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module pscb_ctrl
  import pscb_pkg::*;
#(
  parameter int RST_W = 8
)(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             auto_reduced_power_enable,
  output logic             state_machine_reset,
  output logic             mgmt_preamble_suppress,
  output logic             sleep_power_down,
  output logic             remote_loop_out
);

  // elaboration-time guard on the reset length counter width
  generate
    if (RST_W < 2 || RST_W > 16)
    begin : g_bad_rst_w
      $error("pscb_ctrl: RST_W must lie in 2..16");
    end
  endgenerate

  localparam logic [RST_W-1:0] SM_LEN_RESET = RST_W'(SM_RESET_CYCLES);

  typedef struct packed {
    logic             aw_hold;
    logic [7:0]       aw_addr;
    logic             w_hold;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic [15:0]      cfg;
    logic [RST_W-1:0] sm_len;
    logic             sm_pend;
    logic             sleep_seen;
  } pscb_st_s;

  pscb_st_s st_ff;
  pscb_st_s nxt_st;

  logic tmr_start;
  logic tmr_busy;
  logic tmr_done;
  logic wr_go;
  logic rd_go;

  // ----------------------------------------------------------------------
  // state machine reset timer
  // ----------------------------------------------------------------------
  pscb_rst_timer #(
    .W     (RST_W)
  ) u_tmr (
    .clk   (clk),
    .rstn  (rstn),
    .start (tmr_start),
    .len   (st_ff.sm_len),
    .busy  (tmr_busy),
    .done  (tmr_done)
  );

  // ----------------------------------------------------------------------
  // bus handshakes
  // ----------------------------------------------------------------------
  // one write and one read in flight; a channel is held until its response
  assign s_axi_awready = !st_ff.aw_hold && !st_ff.bvalid;
  assign s_axi_wready  = !st_ff.w_hold && !st_ff.bvalid;
  assign s_axi_arready = !st_ff.rvalid;
  assign wr_go = (st_ff.aw_hold || (s_axi_awvalid && s_axi_awready)) &&
                 (st_ff.w_hold  || (s_axi_wvalid  && s_axi_wready)) &&
                 !st_ff.bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic [7:0]  a;
    logic [31:0] d;
    logic [3:0]  s;
    logic [15:0] c;
    logic        wake;
    a      = 8'h00;
    d      = 32'h0000_0000;
    s      = 4'h0;
    c      = 16'h0000;
    wake   = 1'b0;
    nxt_st = st_ff;
    tmr_start = 1'b0;

    // capture address and data in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      nxt_st.aw_hold = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      nxt_st.w_hold = 1'b1;
      nxt_st.w_data = s_axi_wdata;
      nxt_st.w_strb = s_axi_wstrb;
    end

    // response handshakes
    if (st_ff.bvalid && s_axi_bready)
      nxt_st.bvalid = 1'b0;
    if (st_ff.rvalid && s_axi_rready)
      nxt_st.rvalid = 1'b0;

    // self-clear when the reset pulse ends
    if (tmr_done)
      nxt_st.cfg[STATE_MACHINE_RESET_BIT] = 1'b0;

    // register write; only low lanes matter, the upper bits are reserved
    if (wr_go)
    begin
      a = st_ff.aw_hold ? st_ff.aw_addr : s_axi_awaddr;
      d = st_ff.w_hold  ? st_ff.w_data  : s_axi_wdata;
      s = st_ff.w_hold  ? st_ff.w_strb  : s_axi_wstrb;
      nxt_st.aw_hold = 1'b0;
      nxt_st.w_hold  = 1'b0;
      nxt_st.bvalid  = 1'b1;
      nxt_st.bresp   = RESP_OKAY;
      unique case ({a[7:2], 2'b00})
        SPECIFIC_CONFIGURATION_OFS:
        begin
          // start from the next value so a self-clear in this cycle sticks
          c = nxt_st.cfg;
          if (s[0])
          begin
            c[ARPD_BIT]  = d[ARPD_BIT];
            c[MPS_BIT]   = d[MPS_BIT];
            c[SLEEP_BIT] = d[SLEEP_BIT];
            c[RLO_BIT]   = d[RLO_BIT];
            // writing one launches the reset; zero does not cancel
            if (d[STATE_MACHINE_RESET_BIT])
            begin
              c[STATE_MACHINE_RESET_BIT] = 1'b1;
              tmr_start    = 1'b1;
            end
            // leaving sleep resets machines, settings untouched
            wake = st_ff.cfg[SLEEP_BIT] && !d[SLEEP_BIT];
          end
          if (s[1])
            c[15:8] = d[15:8];
          nxt_st.cfg = c;
        end
        SM_RESET_LEN_OFS:
        begin
          if (s[0] && d[RST_W-1:0] != '0)
            nxt_st.sm_len = d[RST_W-1:0];
        end
        STATUS_OFS:
        begin
          nxt_st.bresp = RESP_OKAY;
        end
        default:
        begin
          nxt_st.bresp = RESP_SLVERR;
        end
      endcase
      // wake reset shows in bit 3 until it completes
      if (wake)
      begin
        nxt_st.cfg[STATE_MACHINE_RESET_BIT] = 1'b1;
        tmr_start = 1'b1;
      end
    end

    if (rd_go)
    begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp  = RESP_OKAY;
      unique case ({s_axi_araddr[7:2], 2'b00})
        SPECIFIC_CONFIGURATION_OFS:
          nxt_st.rdata = {16'h0000, st_ff.cfg};
        SM_RESET_LEN_OFS:
          nxt_st.rdata = 32'(st_ff.sm_len);
        STATUS_OFS:
          nxt_st.rdata = {30'h0, st_ff.cfg[SLEEP_BIT], tmr_busy};
        default:
        begin
          nxt_st.rdata = 32'h0000_0000;
          nxt_st.rresp = RESP_SLVERR;
        end
      endcase
    end
    nxt_st.sm_pend    = tmr_busy;
    nxt_st.sleep_seen = st_ff.cfg[SLEEP_BIT];
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_ff        <= '0;
      st_ff.cfg    <= CFG_RESET;
      st_ff.sm_len <= SM_LEN_RESET;
    end
    else
      st_ff <= nxt_st;
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp  = st_ff.bresp;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata  = st_ff.rdata;
  assign s_axi_rresp  = st_ff.rresp;

  // power-down permission straight from the register
  assign auto_reduced_power_enable = st_ff.cfg[ARPD_BIT];
  // machines held in reset while the timer runs
  assign state_machine_reset       = tmr_busy;
  assign mgmt_preamble_suppress    = st_ff.cfg[MPS_BIT];
  // sleep gates everything but oscillator and clock generator
  assign sleep_power_down          = st_ff.cfg[SLEEP_BIT];
  assign remote_loop_out           = st_ff.cfg[RLO_BIT];

endmodule // pscb_ctrl
`default_nettype wire

// [tb/pscb_checker.sv]
// checker for the special control bits: pins against config writes
// assumes address and data of a write are offered together
`timescale 1ns/10ps
`default_nettype none
module pscb_checker
  import pscb_pkg::*;
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        auto_reduced_power_enable,
  input wire logic        state_machine_reset,
  input wire logic        mgmt_preamble_suppress,
  input wire logic        sleep_power_down,
  input wire logic        remote_loop_out
);
  logic hit;
  int   hi_cnt_ff;
  int   nxt_hi_cnt;

  // low lane write to the config word, both channels in one edge
  assign hit = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready && s_axi_awaddr == SPECIFIC_CONFIGURATION_OFS &&
    s_axi_wstrb[0];

  // length of the reset pulse; a restart mid-pulse would skew it
  always_comb nxt_hi_cnt = state_machine_reset ? hi_cnt_ff + 1 : 0;
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      hi_cnt_ff <= 0;
    else
      hi_cnt_ff <= nxt_hi_cnt;

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_cfg_wr;
    hit;
  endsequence
  property p_bit(logic o, logic d);
    s_cfg_wr |=> o == $past(d);
  endproperty

  AST_LOOP_BIT: assert property (p_bit(remote_loop_out,
    s_axi_wdata[RLO_BIT])) else $error("loop-out pin off");
  AST_SLEEP_BIT: assert property (p_bit(sleep_power_down,
    s_axi_wdata[SLEEP_BIT])) else $error("sleep pin off");
  AST_PRE_BIT: assert property (p_bit(mgmt_preamble_suppress,
    s_axi_wdata[MPS_BIT])) else $error("preamble pin off");
  AST_ARPD_BIT: assert property (p_bit(auto_reduced_power_enable,
    s_axi_wdata[ARPD_BIT])) else $error("power pin off");
  AST_ARPD_HOLD: assert property (!hit |=>
    $stable(auto_reduced_power_enable)) else $error("power pin moved");
  AST_SMR_GO: assert property (s_cfg_wr ##0 s_axi_wdata[STATE_MACHINE_RESET_BIT]
    |=> state_machine_reset) else $error("reset not started");
  AST_SMR_LEN: assert property ($fell(state_machine_reset) |->
    hi_cnt_ff == SM_RESET_CYCLES) else $error("reset length wrong");
  AST_WAKE: assert property ($fell(sleep_power_down) |->
    ##[0:1] state_machine_reset) else $error("wake without reset");
endmodule // pscb_checker

bind pscb_ctrl pscb_checker u_chk (.*);
`default_nettype wire

// [tb/pscb_axi_master.sv]
// axi4-lite master standing in for the station manager
// assumes bready and rready are tied high by the bench
`timescale 1ns/10ps
`default_nettype none
module pscb_axi_master
(
  input  wire logic        clk,
  output logic [7:0]       s_axi_awaddr = '0,
  output logic             s_axi_awvalid = 1'b0,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata = '0,
  output logic [3:0]       s_axi_wstrb = '0,
  output logic             s_axi_wvalid = 1'b0,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic [7:0]       s_axi_araddr = '0,
  output logic             s_axi_arvalid = 1'b0,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid
);
  // response code of the last finished write
  logic [1:0] last_bresp = 2'h0;

  // ----------------------------------------------------------------
  // bus cycles; a stuck slave ends the run instead of hanging
  // ----------------------------------------------------------------
  task automatic tick(inout int n);
    @(posedge clk);
    n++;
    if (n > 64)
    begin
      testbench.error_cnt++;
      testbench.conclude();
    end
  endtask

  // both channels offered at once, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int   n;
    logic aw_t;
    logic w_t;
    logic b_t;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      // sample mid-cycle, where the slave's answers have settled
      @(negedge clk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t  = s_axi_wvalid && s_axi_wready;
      b_t  = s_axi_bvalid;
      if (b_t)
        last_bresp = s_axi_bresp;
      tick(n);
      if (aw_t)
        s_axi_awvalid <= 1'b0;
      if (w_t)
        s_axi_wvalid <= 1'b0;
    end
    while (!b_t);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int   n;
    logic ar_t;
    logic r_t;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(negedge clk);
      ar_t = s_axi_arvalid && s_axi_arready;
      r_t  = s_axi_rvalid;
      d    = s_axi_rdata;
      r    = s_axi_rresp;
      tick(n);
      if (ar_t)
        s_axi_arvalid <= 1'b0;
    end
    while (!r_t);
  endtask
endmodule // pscb_axi_master
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the special control bits block
// assumes the default reset length register value is left alone
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import pscb_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        s_axi_bready = 1'b1;
  logic        s_axi_rready = 1'b1;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        auto_reduced_power_enable, state_machine_reset;
  logic        mgmt_preamble_suppress, sleep_power_down, remote_loop_out;
  int          error_cnt = 0;
  int          checks = 0;
  // pin order matches the bit order of the config word
  logic [31:0] wtab [5] = '{32'h01, 32'h10, 32'h04, 32'h07, 32'h05};
  logic [4:0]  ptab [5] = '{5'h01, 5'h10, 5'h04, 5'h07, 5'h0d};

  always #4 clk = ~clk;
  pscb_ctrl       i_pscb_ctrl (.*);
  pscb_axi_master u_mst (.*);

  // ----------------------------------------------------------------
  // compare and report
  // ----------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_pins(input logic [4:0] exp);
    cmp({27'h0, auto_reduced_power_enable, state_machine_reset,
      mgmt_preamble_suppress, sleep_power_down, remote_loop_out},
      {27'h0, exp});
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp,
                        input logic [1:0] rexp);
    logic [31:0] d;
    logic [1:0]  r;
    u_mst.rd(a, d, r);
    cmp(d, exp);
    cmp({30'h0, r}, {30'h0, rexp});
  endtask

  // bounded wait for the state machine reset to finish
  task automatic wait_idle;
    int n;
    n = 0;
    while (state_machine_reset !== 1'b0)
    begin
      @(posedge clk);
      n++;
      if (n > 40)
      begin
        error_cnt++;
        conclude();
      end
    end
    // bit 3 self-clears one edge after the reset output drops
    repeat (2) @(posedge clk);
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk_rd(SPECIFIC_CONFIGURATION_OFS, 32'h14, RESP_OKAY);
    chk_pins(5'h14);
    $display("test reset values done");
    // last entry wakes from sleep with loop and preamble kept
    for (int i = 0; i < 5; i++)
    begin
      u_mst.wr(SPECIFIC_CONFIGURATION_OFS, wtab[i]);
      @(posedge clk);
      chk_pins(ptab[i]);
      chk_rd(SPECIFIC_CONFIGURATION_OFS, {27'h0, ptab[i]}, RESP_OKAY);
    end
    wait_idle();
    chk_rd(SPECIFIC_CONFIGURATION_OFS, 32'h05, RESP_OKAY);
    $display("test field access done");
    u_mst.wr(SPECIFIC_CONFIGURATION_OFS, 32'h18);
    @(posedge clk);
    chk_pins(5'h18);
    chk_rd(SPECIFIC_CONFIGURATION_OFS, 32'h18, RESP_OKAY);
    wait_idle();
    chk_rd(SPECIFIC_CONFIGURATION_OFS, 32'h10, RESP_OKAY);
    chk_pins(5'h10);
    $display("test state reset done");
    u_mst.wr(8'h20, 32'hffff);
    cmp({30'h0, u_mst.last_bresp}, {30'h0, RESP_SLVERR});
    chk_rd(8'h20, 32'h0, RESP_SLVERR);
    chk_rd(SPECIFIC_CONFIGURATION_OFS, 32'h10, RESP_OKAY);
    $display("test unmapped done");
    conclude();
  end
endmodule // testbench
`default_nettype wire
